/* File: cursor_icon_overlay.sv */
// Purpose: two-plane hardware cursor and icon overlay; cursor on either path, icon on the primary path only
// Assumes: inputs synchronous to i_clk_sys; pixels as three 10-bit channels
// Notes: one pipeline stage from pixel in to pixel out
// Functional notes
// - cursor location: X in 26:16, Y in 10:0, read-write, reset zero
// - cursor origin: X in 26:16, Y in 10:0, other bits read zero
// - background colour uses low 8, 15, 16 or 24 bits by depth
// - foreground colour uses low 8, 15, 16 or 24 bits by depth
// - AND zero: XOR zero gives background, XOR one gives foreground
// - AND one: XOR zero passes screen pixel, XOR one inverts its depth-significant bits
// - cursor pixel rule applies only in graphics modes
// - pre-threshold in 31:24 lets the fetcher request early
// - threshold in 15:8 raises fetch priority from low to high
// - colour key significant bits follow the icon pixel format
// - control bit 30 prefetch, bit 2 blend, bit 0 icon enable
// - bit 29 selects icon term plus one-minus-alpha times graphics
// - bit 28 picks constant alpha or per-pixel alpha 31:24
// - size field 27:26: 32, 64, or 128 when upper bit set
// - format field 25:24: 555, 565, RGB32, RGB10
// - constant alpha upper nibble 7:4, lower 19:16, both reset all ones
// - fade bit 8 steps alpha each frame by 15:12; upper nibble used
// - bit 9 one fades in by adding the step, zero subtracts
// - image start address in 28:4 in 16-byte units
// - target field 30:29 selects memory target, 10 reserved
// - icon overlay acts only on the primary display path
// - cursor mode bit 0 enable, bit 1 size; base 25:10 or 25:8
`timescale 1ns/1ps
module cursor_icon_overlay
  import cursor_icon_pkg::*;
#(
  parameter int FIFO_DEPTH = 64
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_pix_valid,
  input wire logic [29:0] i_gfx_pix,
  input wire logic i_graphics_mode,
  input wire logic [1:0] i_colour_depth,
  input wire logic i_primary_path,
  input wire logic i_cursor_hit,
  input wire logic i_and_bit,
  input wire logic i_xor_bit,
  input wire logic i_icon_hit,
  input wire logic [31:0] i_icon_pix,
  input wire logic i_frame_start,
  input wire logic [7:0] i_fifo_level,
  output logic o_pix_valid,
  output logic [29:0] o_pix,
  output logic o_fetch_req,
  output logic o_fetch_high_pri,
  output logic [28:0] o_fetch_addr,
  output logic [1:0] o_fetch_target,
  output logic [7:0] o_icon_edge,
  output logic o_cursor_en,
  output logic o_cursor_small,
  output logic [25:0] o_cursor_base,
  output logic [1:0] o_cursor_target
);

  ////////////////////////////////////////////////////////////////////////
  // state and helpers

  typedef struct packed {
    logic [31:0] cur_mode;
    logic [31:0] cur_loc;
    logic [31:0] cur_org;
    logic [31:0] cur_back;
    logic [31:0] cur_front;
    logic [31:0] fifo_lvl;
    logic [31:0] key;
    logic [31:0] ctrl;
    logic [31:0] base;
    logic [7:0] alpha;
    logic [31:0] rdata;
    logic [29:0] pix;
    logic pix_vld;
    logic req;
    logic hipri;
  } state_t;

  localparam logic [7:0] DEPTH_M1 = 8'(FIFO_DEPTH - 1);

  state_t st_q;
  state_t st_d;

  // significant cursor colour bits for a colour depth
  function automatic logic [29:0] depth_mask(input logic [1:0] dep);
    logic [29:0] m;
    m = 30'h0000_00FF;
    case (dep)
      DEP_555: m = 30'h0000_7FFF;
      DEP_565: m = 30'h0000_FFFF;
      DEP_TRUE: m = 30'h00FF_FFFF;
      default: m = 30'h0000_00FF;
    endcase
    return m;
  endfunction : depth_mask

  // significant colour key bits for an icon format
  function automatic logic [29:0] key_mask(input logic [1:0] fmt);
    logic [29:0] m;
    m = 30'h0000_7FFF;
    case (fmt)
      FMT_565: m = 30'h0000_FFFF;
      FMT_RGB32: m = 30'h00FF_FFFF;
      FMT_RGB10: m = 30'h3FFF_FFFF;
      default: m = 30'h0000_7FFF;
    endcase
    return m;
  endfunction : key_mask

  // mixes one 10-bit channel, saturating at full scale
  function automatic logic [9:0] mix(input logic [9:0] ic,
                                     input logic [9:0] gf,
                                     input logic [7:0] a,
                                     input logic premul);
    logic [8:0] wa;
    logic [8:0] wg;
    logic [19:0] s;
    wa = premul ? ALPHA_ONE : {1'b0, a};
    wg = ALPHA_ONE - {1'b0, a};
    s = 20'(20'(ic) * 20'(wa)) + 20'(20'(gf) * 20'(wg));
    return (s[19:18] != 2'b00) ? CHAN_MAX : s[17:8];
  endfunction : mix

  ////////////////////////////////////////////////////////////////////////
  // combinational decode of the control words

  logic icon_on;
  logic [29:0] kmask;
  logic [29:0] dmask;
  logic [7:0] const_alpha;
  logic [7:0] use_alpha;
  logic [29:0] icon_rgb;
  logic [29:0] blended;
  logic [29:0] after_icon;
  logic keyed;

  // icon only ever acts on the primary path
  assign icon_on = st_q.ctrl[IC_EN] & i_primary_path;
  assign kmask = key_mask(st_q.ctrl[IC_FMT +: 2]);
  assign dmask = depth_mask(i_colour_depth);
  // constant alpha is split over two nibbles of the control word
  assign const_alpha = {st_q.ctrl[IC_ALPHA_HI +: 4],
                        st_q.ctrl[IC_ALPHA_LO +: 4]};
  assign icon_rgb = i_icon_pix[29:0];
  assign keyed = ((icon_rgb ^ st_q.key[29:0]) & kmask) == 30'h0;

  // alpha source: per-pixel, faded running value, or constant
  always_comb begin
    if (st_q.ctrl[IC_ALPHA_SRC]) begin
      use_alpha = i_icon_pix[31:24];
    end else if (st_q.ctrl[IC_FADE_EN]) begin
      use_alpha = {st_q.alpha[7:4], st_q.alpha[7:4]};
    end else begin
      use_alpha = const_alpha;
    end
  end

  // three channel mix of icon over graphics
  always_comb begin
    blended = 30'h0;
    for (int c = 0; c < 3; c++) begin
      blended[c*10 +: 10] = mix(icon_rgb[c*10 +: 10], i_gfx_pix[c*10 +: 10],
                                use_alpha, st_q.ctrl[IC_PREMUL]);
    end
  end

  // icon stage: key hides, blend mixes, else icon replaces
  always_comb begin
    if (!icon_on || !i_icon_hit || keyed) begin
      after_icon = i_gfx_pix;
    end else if (st_q.ctrl[IC_BLEND]) begin
      after_icon = blended;
    end else begin
      after_icon = icon_rgb;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    logic [8:0] sum;
    logic cursor_on;
    sum = 9'h0;
    cursor_on = 1'b0;
    st_d = st_q;
    // register writes keep only the writable bits
    if (i_wr) begin
      if (i_addr == OFS_CUR_MODE) begin
        st_d.cur_mode = i_wdata & MSK_CUR_MODE;
      end else if (i_addr == OFS_CUR_LOC) begin
        st_d.cur_loc = i_wdata & MSK_XY;
      end else if (i_addr == OFS_CUR_ORG) begin
        st_d.cur_org = i_wdata & MSK_XY;
      end else if (i_addr == OFS_CUR_BACK) begin
        st_d.cur_back = i_wdata & MSK_COLOUR;
      end else if (i_addr == OFS_CUR_FRONT) begin
        st_d.cur_front = i_wdata & MSK_COLOUR;
      end else if (i_addr == OFS_FIFO_LVL) begin
        st_d.fifo_lvl = i_wdata & MSK_FIFO_LVL;
      end else if (i_addr == OFS_KEY) begin
        st_d.key = i_wdata & MSK_KEY;
      end else if (i_addr == OFS_CTRL) begin
        st_d.ctrl = i_wdata & MSK_CTRL;
      end else if (i_addr == OFS_BASE) begin
        st_d.base = i_wdata & MSK_BASE;
      end
    end
    // read data stands only in the cycle after the strobe
    st_d.rdata = 32'h0;
    if (i_rd) begin
      if (i_addr == OFS_CUR_MODE) begin
        st_d.rdata = st_q.cur_mode;
      end else if (i_addr == OFS_CUR_LOC) begin
        st_d.rdata = st_q.cur_loc;
      end else if (i_addr == OFS_CUR_ORG) begin
        st_d.rdata = st_q.cur_org;
      end else if (i_addr == OFS_CUR_BACK) begin
        st_d.rdata = st_q.cur_back;
      end else if (i_addr == OFS_CUR_FRONT) begin
        st_d.rdata = st_q.cur_front;
      end else if (i_addr == OFS_FIFO_LVL) begin
        st_d.rdata = st_q.fifo_lvl | {24'h0, DEPTH_M1};
      end else if (i_addr == OFS_KEY) begin
        st_d.rdata = st_q.key;
      end else if (i_addr == OFS_CTRL) begin
        st_d.rdata = st_q.ctrl;
      end else if (i_addr == OFS_BASE) begin
        st_d.rdata = st_q.base;
      end
    end
    // per-frame fade, saturating at both ends
    if (!st_q.ctrl[IC_FADE_EN]) begin
      st_d.alpha = const_alpha;
    end else if (i_frame_start) begin
      if (st_q.ctrl[IC_FADE_IN]) begin
        sum = {1'b0, st_q.alpha} + {5'h0, st_q.ctrl[IC_STEP +: 4]};
        st_d.alpha = sum[8] ? 8'hFF : sum[7:0];
      end else begin
        sum = {1'b0, st_q.alpha} - {5'h0, st_q.ctrl[IC_STEP +: 4]};
        st_d.alpha = sum[8] ? 8'h00 : sum[7:0];
      end
    end
    // cursor sits above the icon; graphics modes only
    cursor_on = st_q.cur_mode[CM_EN] & i_graphics_mode & i_cursor_hit;
    st_d.pix_vld = i_pix_valid;
    if (i_pix_valid) begin
      if (!cursor_on) begin
        st_d.pix = after_icon;
      end else if (!i_and_bit) begin
        st_d.pix = i_xor_bit ? (st_q.cur_front[29:0] & dmask)
                             : (st_q.cur_back[29:0] & dmask);
      end else begin
        st_d.pix = i_xor_bit ? (after_icon ^ dmask) : after_icon;
      end
    end
    // fetch request: early level when prefetch is on
    st_d.hipri = icon_on &
                 (i_fifo_level < st_q.fifo_lvl[FL_THR +: 8]);
    st_d.req = icon_on & (st_q.ctrl[IC_PREFETCH] ?
               (i_fifo_level < st_q.fifo_lvl[FL_PRE +: 8]) :
               (i_fifo_level < st_q.fifo_lvl[FL_THR +: 8]));
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= '0;
      st_q.ctrl <= RST_CTRL;
      st_q.alpha <= 8'hFF;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_rdata = st_q.rdata;
  assign o_pix_valid = st_q.pix_vld;
  assign o_pix = st_q.pix;
  assign o_fetch_req = st_q.req;
  assign o_fetch_high_pri = st_q.hipri;
  assign o_fetch_addr = {st_q.base[28:BA_ADDR], 4'h0};
  assign o_fetch_target = st_q.base[BA_TGT +: 2];
  assign o_icon_edge = st_q.ctrl[IC_SIZE + 1] ? ICON_128 :
                       (st_q.ctrl[IC_SIZE] ? ICON_64 : ICON_32);
  assign o_cursor_en = st_q.cur_mode[CM_EN];
  assign o_cursor_small = st_q.cur_mode[CM_SIZE];
  // large pattern aligns its base to 1 KiB
  assign o_cursor_base = st_q.cur_mode[CM_SIZE] ?
                         {st_q.cur_mode[25:8], 8'h00} :
                         {st_q.cur_mode[25:10], 10'h000};
  assign o_cursor_target = st_q.cur_mode[30:29];

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  sequence s_fg_pix;
    i_pix_valid && i_graphics_mode && i_cursor_hit && o_cursor_en &&
    !i_and_bit && i_xor_bit;
  endsequence

  property p_loc_reserved;
    i_wr && i_addr == OFS_CUR_LOC ##1 i_rd && i_addr == OFS_CUR_LOC
      |=> o_rdata[31:27] == 5'h0 && o_rdata[15:11] == 5'h0;
  endproperty
  a_loc_reserved: assert property (p_loc_reserved)
    else $error("cursor location reserved bits not zero");

  property p_org_readback;
    i_wr && i_addr == OFS_CUR_ORG ##1 i_rd && i_addr == OFS_CUR_ORG
      |=> o_rdata == ($past(i_wdata, 2) & MSK_XY);
  endproperty
  a_org_readback: assert property (p_org_readback)
    else $error("cursor origin readback wrong");

  property p_fg;
    s_fg_pix |=> o_pix == ($past(st_q.cur_front[29:0]) & $past(dmask));
  endproperty
  a_fg: assert property (p_fg)
    else $error("cursor foreground pixel wrong");

  property p_invert;
    i_pix_valid && i_graphics_mode && i_cursor_hit && o_cursor_en &&
    i_and_bit && i_xor_bit |=> o_pix == ($past(after_icon) ^ $past(dmask));
  endproperty
  a_invert: assert property (p_invert)
    else $error("cursor inverted pixel wrong");

  property p_text_mode;
    i_pix_valid && !i_graphics_mode |=> o_pix == $past(after_icon);
  endproperty
  a_text_mode: assert property (p_text_mode)
    else $error("cursor applied in text mode");

  property p_key;
    i_pix_valid && !i_cursor_hit && keyed |=> o_pix == $past(i_gfx_pix);
  endproperty
  a_key: assert property (p_key)
    else $error("keyed icon pixel shown");

  property p_secondary;
    i_pix_valid && !i_primary_path && !i_cursor_hit
      |=> o_pix == $past(i_gfx_pix);
  endproperty
  a_secondary: assert property (p_secondary)
    else $error("icon drawn on secondary path");

  property p_hipri;
    st_q.ctrl[IC_EN] && i_primary_path &&
    i_fifo_level < st_q.fifo_lvl[FL_THR +: 8] |=> o_fetch_high_pri;
  endproperty
  a_hipri: assert property (p_hipri)
    else $error("high priority not raised");

  property p_fade_in;
    st_q.ctrl[IC_FADE_EN] && st_q.ctrl[IC_FADE_IN] && i_frame_start &&
    st_q.alpha <= 8'hF0
      |=> st_q.alpha == $past(st_q.alpha) + 8'($past(st_q.ctrl[15:12]));
  endproperty
  a_fade_in: assert property (p_fade_in)
    else $error("fade-in step wrong");

  // compare against the constant of the previous cycle, since a control
  // write may change the constant in the very cycle alpha follows it
  property p_fade_off;
    !st_q.ctrl[IC_FADE_EN] |=> st_q.alpha == $past(const_alpha);
  endproperty
  a_fade_off: assert property (p_fade_off)
    else $error("alpha not at constant without fade");

endmodule : cursor_icon_overlay

/* File: cursor_icon_overlay_tb.sv */
// Purpose: self-checking bench for the cursor and icon overlay
// Assumes: fetch model fills the icon fifo on request
// Notes: fifo depth set to 32 so its readback is checked against it
`timescale 1ns/1ps
module cursor_icon_overlay_tb;
  import cursor_icon_pkg::*;
  localparam logic [29:0] IC = 30'h3FF8_0000;
  localparam logic [29:0] GB = 30'h0004_03FF;
  logic clk_sys = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0, ipix = 32'h0, rdata;
  logic pix_valid = 1'b0, gmode = 1'b0, prim = 1'b0, chit = 1'b0;
  logic and_bit = 1'b0, xor_bit = 1'b0, ihit = 1'b0, fstart = 1'b0;
  logic fill_en = 1'b0, load = 1'b0;
  logic [29:0] gfx = 30'h0, pix_out;
  logic [1:0] depth = 2'h0, ftgt, ctgt;
  logic [7:0] load_level = 8'h00, level, edge_len;
  logic pv_out, req, hpri, cur_en, cur_small;
  logic [28:0] faddr;
  logic [25:0] cbase;
  int num_errors = 0, checks = 0, cycles = 0;
  ////////////////////////////////////////////////////////////////////////////
  // clock, design and fetch model
  always #4 clk_sys = ~clk_sys;
  cursor_icon_overlay #(.FIFO_DEPTH(32)) i_dut (.i_clk_sys(clk_sys),
    .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_pix_valid(pix_valid), .i_gfx_pix(gfx),
    .i_graphics_mode(gmode), .i_colour_depth(depth), .i_primary_path(prim),
    .i_cursor_hit(chit), .i_and_bit(and_bit), .i_xor_bit(xor_bit),
    .i_icon_hit(ihit), .i_icon_pix(ipix), .i_frame_start(fstart),
    .i_fifo_level(level), .o_pix_valid(pv_out), .o_pix(pix_out),
    .o_fetch_req(req), .o_fetch_high_pri(hpri), .o_fetch_addr(faddr),
    .o_fetch_target(ftgt), .o_icon_edge(edge_len), .o_cursor_en(cur_en),
    .o_cursor_small(cur_small), .o_cursor_base(cbase),
    .o_cursor_target(ctgt));
  icon_fetch_model #(.GAP(4)) i_fetch (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
    .i_req(req), .i_fill_en(fill_en), .i_load(load),
    .i_load_level(load_level), .o_level(level));
  ////////////////////////////////////////////////////////////////////////////
  // verdict and shared helpers
  task automatic conclude();
    if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    check(rdata, exp);
  endtask : reg_chk
  // write, then read the same word back in the very next cycle, no gap
  task automatic wr_rd(input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] exp);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    check(rdata, exp);
  endtask : wr_rd
  task automatic ctx(input logic gm, input logic [1:0] dp, input logic pr);
    @(posedge clk_sys);
    gmode <= gm;
    depth <= dp;
    prim <= pr;
  endtask : ctx
  task automatic frame();
    @(posedge clk_sys);
    fstart <= 1'b1;
    @(posedge clk_sys);
    fstart <= 1'b0;
  endtask : frame
  task automatic ld(input logic [7:0] v);
    @(posedge clk_sys);
    load <= 1'b1;
    load_level <= v;
    @(posedge clk_sys);
    load <= 1'b0;
  endtask : ld
  // one pixel in, result checked in the following cycle
  task automatic pix(input logic [2:0] cax, input logic ih,
      input logic [31:0] ip, input logic [29:0] g, input logic [29:0] exp);
    @(posedge clk_sys);
    {chit, and_bit, xor_bit} <= cax;
    ihit <= ih;
    ipix <= ip;
    gfx <= g;
    pix_valid <= 1'b1;
    @(posedge clk_sys);
    pix_valid <= 1'b0;
    @(negedge clk_sys);
    check({31'h0, pv_out}, 32'h1);
    check({2'b00, pix_out}, {2'b00, exp});
  endtask : pix
  function automatic logic [29:0] mix(input logic [29:0] ic, g,
      input logic [8:0] a, input logic pm);
    logic [29:0] r;
    logic [19:0] s;
    for (int c = 0; c < 30; c += 10) begin
      s = ic[c +: 10] * (pm ? 9'h100 : a) + g[c +: 10] * (9'h100 - a);
      r[c +: 10] = (s[19:8] > 12'h3FF) ? 10'h3FF : s[17:8];
    end
    return r;
  endfunction : mix
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs();
    logic [11:0] ofs [9];
    logic [31:0] wm [9];
    logic [31:0] ro;
    ofs = '{OFS_CUR_MODE, OFS_CUR_LOC, OFS_CUR_ORG, OFS_CUR_BACK,
      OFS_CUR_FRONT, OFS_FIFO_LVL, OFS_KEY, OFS_CTRL, OFS_BASE};
    wm = '{32'h63FF_FF03, 32'h07FF_07FF, 32'h07FF_07FF, 32'h00FF_FFFF,
      32'h00FF_FFFF, 32'hFF00_FF00, 32'h3FFF_FFFF, 32'h7F0F_F3F5,
      32'h7FFF_FFF0};
    check({24'h0, edge_len}, 32'h20);
    for (int i = 0; i < 9; i++) begin
      ro = (i == 5) ? 32'h0000_001F : 32'h0;
      reg_chk(ofs[i], (i == 7) ? 32'h000F_00F0 : ro);
      wr_rd(ofs[i], 32'hFFFF_FFFF, wm[i] | ro);
      reg_wr(ofs[i], 32'h0);
      reg_chk(ofs[i], ro);
    end
    reg_wr(12'h2E4, 32'hFFFF_FFFF);
    reg_chk(12'h2E4, 32'h0);
  endtask : t_regs
  task automatic t_fields();
    logic [7:0] el [4];
    el = '{8'h20, 8'h40, 8'h80, 8'h80};
    reg_wr(OFS_CUR_MODE, 32'h63FF_FF03);
    @(negedge clk_sys);
    check({cur_en, cur_small, ctgt, 2'b00, cbase}, 32'hF3FF_FF00);
    reg_wr(OFS_CUR_MODE, 32'h03FF_FF01);
    @(negedge clk_sys);
    check({cur_en, cur_small, ctgt, 2'b00, cbase}, 32'h83FF_FC00);
    reg_wr(OFS_BASE, 32'hFFFF_FFFF);
    @(negedge clk_sys);
    check({ftgt, 1'b0, faddr}, 32'hDFFF_FFF0);
    for (int s = 0; s < 4; s++) begin
      reg_wr(OFS_CTRL, 32'(s) << 26);
      @(negedge clk_sys);
      check({24'h0, edge_len}, {24'h0, el[s]});
    end
  endtask : t_fields
  task automatic t_cursor();
    logic [29:0] dm, g;
    g = 30'h2AAA_AAAA;
    reg_wr(OFS_CUR_MODE, 32'h0000_0001);
    reg_wr(OFS_CUR_BACK, 32'h00AB_CDEF);
    reg_wr(OFS_CUR_FRONT, 32'h0012_3456);
    for (int d = 0; d < 4; d++) begin
      dm = (d == 0) ? 30'hFF : (d == 1) ? 30'h7FFF : (d == 2) ? 30'hFFFF
        : 30'hFF_FFFF;
      ctx(1'b1, d[1:0], 1'b1);
      pix(3'b100, 1'b0, 32'h0, g, 30'hAB_CDEF & dm);
      pix(3'b101, 1'b0, 32'h0, g, 30'h12_3456 & dm);
      pix(3'b110, 1'b0, 32'h0, g, g);
      pix(3'b111, 1'b0, 32'h0, g, g ^ dm);
    end
    ctx(1'b0, 2'h3, 1'b1);
    pix(3'b100, 1'b0, 32'h0, g, g);
  endtask : t_cursor
  task automatic t_icon();
    logic [29:0] m [4];
    logic [29:0] key, ip;
    m = '{30'h7FFF, 30'hFFFF, 30'hFF_FFFF, 30'h3FFF_FFFF};
    key = 30'h1555_5555;
    reg_wr(OFS_CUR_MODE, 32'h0);
    reg_wr(OFS_KEY, {2'b00, key});
    ctx(1'b1, 2'h3, 1'b1);
    for (int f = 0; f < 4; f++) begin
      reg_wr(OFS_CTRL, (32'(f) << 24) | 32'h1);
      ip = (key & m[f]) | (~key & ~m[f]);
      pix(3'b000, 1'b1, {2'b00, ip}, 30'h5, 30'h5);
      pix(3'b000, 1'b1, {2'b00, ip ^ 30'h1}, 30'h5, ip ^ 30'h1);
    end
    ctx(1'b1, 2'h3, 1'b0);
    pix(3'b000, 1'b1, 32'h1, 30'h5, 30'h5);
  endtask : t_icon
  task automatic t_blend();
    ctx(1'b1, 2'h3, 1'b1);
    reg_wr(OFS_KEY, 32'h0);
    reg_wr(OFS_CTRL, 32'h0300_0085);
    pix(3'b000, 1'b1, {2'b00, IC}, GB, mix(IC, GB, 9'h80, 1'b0));
    reg_wr(OFS_CTRL, 32'h2305_0085);
    pix(3'b000, 1'b1, {2'b00, IC}, GB, mix(IC, GB, 9'h85, 1'b1));
    reg_wr(OFS_CTRL, 32'h1300_0085);
    pix(3'b000, 1'b1, {2'b01, IC}, GB, mix(IC, GB, 9'h7F, 1'b0));
    reg_wr(OFS_CTRL, 32'h0300_4385);
    pix(3'b000, 1'b1, {2'b00, IC}, GB, mix(IC, GB, 9'h88, 1'b0));
    repeat (4) frame();
    pix(3'b000, 1'b1, {2'b00, IC}, GB, mix(IC, GB, 9'h99, 1'b0));
    reg_wr(OFS_CTRL, 32'h0300_4185);
    repeat (3) frame();
    pix(3'b000, 1'b1, {2'b00, IC}, GB, mix(IC, GB, 9'h88, 1'b0));
    reg_wr(OFS_CTRL, 32'h0300_F385);
    repeat (20) frame();
    pix(3'b000, 1'b1, {2'b00, IC}, GB, mix(IC, GB, 9'hFF, 1'b0));
  endtask : t_blend
  task automatic t_fetch();
    int n;
    reg_wr(OFS_FIFO_LVL, 32'h2000_1000);
    reg_wr(OFS_CTRL, 32'h0000_0001);
    ctx(1'b1, 2'h3, 1'b1);
    ld(8'h08);
    fill_en <= 1'b1;
    repeat (2) @(negedge clk_sys);
    check({30'h0, req, hpri}, 32'h3);
    n = 0;
    while (hpri === 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    check({23'h0, req, level}, 32'h10);
    reg_wr(OFS_CTRL, 32'h4000_0001);
    repeat (2) @(negedge clk_sys);
    check({31'h0, req}, 32'h1);
    n = 0;
    while (req === 1'b1 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    check({23'h0, hpri, level}, 32'h20);
    fill_en <= 1'b0;
    ctx(1'b1, 2'h3, 1'b0);
    ld(8'h08);
    repeat (2) @(negedge clk_sys);
    check({30'h0, req, hpri}, 32'h0);
  endtask : t_fetch
  ////////////////////////////////////////////////////////////////////////////
  // main sequence and hang guard
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    t_regs();
    t_fields();
    t_cursor();
    t_icon();
    t_blend();
    t_fetch();
    conclude();
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end
endmodule : cursor_icon_overlay_tb

/* File: cursor_icon_pkg.sv */
// Purpose: shared constants for the cursor and icon overlay block
// Assumes: 32-bit register words at byte offsets, 12-bit byte address
// Notes: write masks clear reserved bits; all read zero but fifo level bits 7:0, which read depth minus one
package cursor_icon_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_CUR_MODE = 12'h2D0;
  localparam logic [11:0] OFS_CUR_LOC = 12'h2D4;
  localparam logic [11:0] OFS_CUR_ORG = 12'h2D8;
  localparam logic [11:0] OFS_CUR_BACK = 12'h2DC;
  localparam logic [11:0] OFS_CUR_FRONT = 12'h2E0;
  localparam logic [11:0] OFS_FIFO_LVL = 12'h2E8;
  localparam logic [11:0] OFS_KEY = 12'h2EC;
  localparam logic [11:0] OFS_CTRL = 12'h2F0;
  localparam logic [11:0] OFS_BASE = 12'h2F4;
  // writable bits of each register
  localparam logic [31:0] MSK_CUR_MODE = 32'h63FF_FF03;
  localparam logic [31:0] MSK_XY = 32'h07FF_07FF;
  localparam logic [31:0] MSK_COLOUR = 32'h00FF_FFFF;
  localparam logic [31:0] MSK_FIFO_LVL = 32'hFF00_FF00;
  localparam logic [31:0] MSK_KEY = 32'h3FFF_FFFF;
  localparam logic [31:0] MSK_CTRL = 32'h7F0F_F3F5;
  localparam logic [31:0] MSK_BASE = 32'h7FFF_FFF0;
  // reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_CTRL = 32'h000F_00F0;
  // cursor mode fields
  localparam int CM_EN = 0;
  localparam int CM_SIZE = 1;
  // icon control fields
  localparam int IC_EN = 0;
  localparam int IC_BLEND = 2;
  localparam int IC_ALPHA_HI = 4;
  localparam int IC_FADE_EN = 8;
  localparam int IC_FADE_IN = 9;
  localparam int IC_STEP = 12;
  localparam int IC_ALPHA_LO = 16;
  localparam int IC_FMT = 24;
  localparam int IC_SIZE = 26;
  localparam int IC_ALPHA_SRC = 28;
  localparam int IC_PREMUL = 29;
  localparam int IC_PREFETCH = 30;
  // fifo level fields
  localparam int FL_THR = 8;
  localparam int FL_PRE = 24;
  // base address fields
  localparam int BA_ADDR = 4;
  localparam int BA_TGT = 29;
  // colour depth and icon format codes
  typedef enum logic [1:0] {DEP_256, DEP_555, DEP_565, DEP_TRUE} depth_t;
  typedef enum logic [1:0] {FMT_555, FMT_565, FMT_RGB32, FMT_RGB10} fmt_t;
  // icon edge lengths in pixels, then full-scale alpha and channel values
  localparam logic [7:0] ICON_32 = 8'h20;
  localparam logic [7:0] ICON_64 = 8'h40;
  localparam logic [7:0] ICON_128 = 8'h80;
  localparam logic [8:0] ALPHA_ONE = 9'h100;
  localparam logic [9:0] CHAN_MAX = 10'h3FF;
endpackage : cursor_icon_pkg

/* File: icon_fetch_model.sv */
// Purpose: frame buffer fetch side that fills the icon fifo
// Assumes: one level of data returns per GAP cycles of standing request
// Notes: the level can be loaded so a scenario starts where it needs
`timescale 1ns/1ps
module icon_fetch_model #(
  parameter int GAP = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_req,
  input wire logic i_fill_en,
  input wire logic i_load,
  input wire logic [7:0] i_load_level,
  output logic [7:0] o_level
);
  int cnt_q;
  ////////////////////////////////////////////////////////////////////////////
  // memory answers slowly: one level per GAP cycles while requested
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_level <= 8'h00;
      cnt_q <= 0;
    end else if (i_load) begin
      o_level <= i_load_level;
      cnt_q <= 0;
    end else if (i_req && i_fill_en) begin
      cnt_q <= (cnt_q == GAP - 1) ? 0 : cnt_q + 1;
      if (cnt_q == GAP - 1) o_level <= o_level + 8'h01;
    end
  end
endmodule : icon_fetch_model
